// ==== design/cc_regs.svh ====
// Constants for the closed-caption line inserter
`ifndef CC_REGS_SVH
`define CC_REGS_SVH
// Register subaddresses of the caption byte pairs
`define CC_EVEN_LO_ADDR 8'h11
`define CC_EVEN_HI_ADDR 8'h12
`define CC_ODD_LO_ADDR 8'h13
`define CC_ODD_HI_ADDR 8'h14
`define CC_ODD_LINE 10'h015
`define CC_EVEN_LINE 10'h11C
`define CC_RUNIN_CYCLES 4'h7
`define CC_GAP_BITS 4'h2
`define CC_DATA_BITS 5'h10
// Caption bit rate 503.5 kHz; clock 10 MHz gives 19 clocks per bit after integer division
`define CC_CLK_HZ 10000000
`define CC_BIT_HZ 503500
`define CC_BIT_CLKS (`CC_CLK_HZ / `CC_BIT_HZ)
`define CC_START_CLKS 16'h0064
`define CC_LEVEL_HIGH 10'h1F4
`define CC_LEVEL_BLANK 10'h0F0
`endif

// ==== design/cc_pkg.sv ====
// Types shared by the caption inserter
package cc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic we;
  } reg_wr_t;
  typedef struct packed {
    logic [9:0] line;
    logic odd_field;
    logic line_start;
  } timing_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_RUNIN = 5'b00100,
    ST_GAP = 5'b01000,
    ST_DATA = 5'b10000
  } cc_state_t;
endpackage : cc_pkg

// ==== design/cc_byte_store.sv ====
// Two byte pairs of caption data, written by subaddress, read registered
`timescale 1ns/10ps
`include "cc_regs.svh"
module cc_byte_store (
  input wire logic clk_sys,
  input wire logic srst,
  input wire cc_pkg::reg_wr_t wr,
  input wire logic sel_odd,
  output logic [15:0] rd_pair
);
  logic [7:0] even_lo;
  logic [7:0] even_hi;
  logic [7:0] odd_lo;
  logic [7:0] odd_hi;
  wire [15:0] next_pair = sel_odd ? {odd_hi, odd_lo} : {even_hi, even_lo};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      even_lo <= 8'h00;
      even_hi <= 8'h00;
      odd_lo <= 8'h00;
      odd_hi <= 8'h00;
      rd_pair <= 16'h0000;
    end else begin
      if (wr.we && wr.addr == `CC_EVEN_LO_ADDR) even_lo <= wr.data;
      if (wr.we && wr.addr == `CC_EVEN_HI_ADDR) even_hi <= wr.data;
      if (wr.we && wr.addr == `CC_ODD_LO_ADDR) odd_lo <= wr.data;
      if (wr.we && wr.addr == `CC_ODD_HI_ADDR) odd_hi <= wr.data;
      rd_pair <= next_pair;
    end
  end
endmodule : cc_byte_store

// ==== design/closed_caption_inserter.sv ====
// Closed-caption waveform inserter for lines 21 and 284
`timescale 1ns/10ps
`include "cc_regs.svh"
module closed_caption_inserter #(
  parameter int BIT_CLKS = `CC_BIT_CLKS,
  parameter logic [15:0] START_CLKS = `CC_START_CLKS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire cc_pkg::reg_wr_t wr,
  input wire cc_pkg::timing_t timing,
  input wire logic [9:0] pixel_in,
  output logic [9:0] pixel_out,
  output logic cc_active
);
  // ********************************
  // State and counters
  // ********************************
  cc_pkg::cc_state_t state;
  cc_pkg::cc_state_t next_state;
  logic [15:0] clk_cnt;
  logic [4:0] bit_cnt;
  logic [16:0] shreg;
  logic caption_line;
  logic [15:0] pair;
  wire [15:0] bit_len = 16'(BIT_CLKS);
  wire [15:0] half_len = 16'(BIT_CLKS / 2);

  // ********************************
  // Helper functions
  // ********************************
  // Written bit 7 is dropped; the parity is always made here
  function automatic logic [7:0] with_parity(input logic [7:0] b);
    with_parity = {~^b[6:0], b[6:0]};
  endfunction : with_parity

  // One luma level per waveform bit, shared by run-in and data
  function automatic logic [9:0] level_of(input logic b);
    level_of = b ? `CC_LEVEL_HIGH : `CC_LEVEL_BLANK;
  endfunction : level_of

  // True on the last clock of a phase that lasts n bit periods
  function automatic logic phase_end(
    input logic [4:0] cnt,
    input logic [4:0] n,
    input logic tick
  );
    phase_end = tick && (cnt == n - 5'h01);
  endfunction : phase_end

  // ********************************
  // Line and state decode
  // ********************************
  wire odd_line = timing.odd_field && (timing.line == `CC_ODD_LINE);
  wire even_line = !timing.odd_field && (timing.line == `CC_EVEN_LINE);
  wire is_cc_line = odd_line || even_line;
  wire line_go = timing.line_start && is_cc_line;
  wire in_wait = (state == cc_pkg::ST_WAIT);
  wire in_runin = (state == cc_pkg::ST_RUNIN);
  wire in_gap = (state == cc_pkg::ST_GAP);
  wire in_data = (state == cc_pkg::ST_DATA);

  // ********************************
  // Phase ends
  // ********************************
  wire bit_end = (clk_cnt == bit_len - 16'h0001);
  // Run-in: one square cycle per bit period, so phase follows the data
  wire runin_done = phase_end(bit_cnt, 5'(`CC_RUNIN_CYCLES), bit_end);
  wire gap_done = phase_end(bit_cnt, 5'(`CC_GAP_BITS), bit_end);
  // Start bit plus the sixteen data bits
  wire data_done = phase_end(bit_cnt, `CC_DATA_BITS + 5'h01, bit_end);
  wire wait_done = (clk_cnt == START_CLKS);

  // ********************************
  // Byte store
  // ********************************
  cc_byte_store u_store (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr(wr),
    .sel_odd(timing.odd_field),
    .rd_pair(pair)
  );

  // ********************************
  // Next state
  // ********************************
  // A caption line that starts mid-sequence is not restarted
  always_comb begin
    next_state = state;
    unique case (state)
      cc_pkg::ST_IDLE: begin
        if (line_go) next_state = cc_pkg::ST_WAIT;
      end
      cc_pkg::ST_WAIT: begin
        if (wait_done) next_state = cc_pkg::ST_RUNIN;
      end
      cc_pkg::ST_RUNIN: begin
        if (runin_done) next_state = cc_pkg::ST_GAP;
      end
      cc_pkg::ST_GAP: begin
        if (gap_done) next_state = cc_pkg::ST_DATA;
      end
      cc_pkg::ST_DATA: begin
        if (data_done) next_state = cc_pkg::ST_IDLE;
      end
      default: next_state = cc_pkg::ST_IDLE;
    endcase
  end

  // ********************************
  // Sequencing
  // ********************************
  wire new_phase = (state != next_state);
  // The wait spans several bit periods, so it counts straight through
  wire wait_count = in_wait && !wait_done;
  wire bit_restart = new_phase || bit_end;
  wire [15:0] clk_inc = clk_cnt + 16'h0001;
  wire [15:0] next_clk = (wait_count || !bit_restart) ? clk_inc : 16'h0000;
  wire [4:0] bit_inc = bit_cnt + 5'h01;
  wire [4:0] bit_step = bit_end ? bit_inc : bit_cnt;
  wire [4:0] next_bit = new_phase ? 5'h00 : bit_step;

  // ********************************
  // Phase counters
  // ********************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= cc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_cnt <= 16'h0000;
    end else begin
      clk_cnt <= next_clk;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bit_cnt <= 5'h00;
    end else begin
      bit_cnt <= next_bit;
    end
  end

  // ********************************
  // Caption bytes
  // ********************************
  // Taken as the gap ends, the last moment before the start bit, so a
  // write made by the preceding line still goes out on this one
  wire load_bytes = in_gap && gap_done;
  wire shift_bit = in_data && bit_end;
  wire [16:0] framed = {with_parity(pair[15:8]), with_parity(pair[7:0]), 1'b1};
  wire [16:0] shifted = {1'b0, shreg[16:1]};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shreg <= 17'h00000;
    end else if (load_bytes) begin
      shreg <= framed;
    end else if (shift_bit) begin
      shreg <= shifted;
    end
  end

  // ********************************
  // Output mux
  // ********************************
  // Line start decides at once, so no pixel of the next line is swallowed
  wire on_cc = timing.line_start ? is_cc_line : caption_line;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      caption_line <= 1'b0;
    end else begin
      caption_line <= on_cc;
    end
  end

  // Square run-in; downstream luma filtering band-limits it toward a sine
  wire runin_level = (clk_cnt < half_len);
  wire [9:0] cc_level = in_runin ? level_of(runin_level) :
    in_data ? level_of(shreg[0]) : `CC_LEVEL_BLANK;
  wire [9:0] next_pixel = on_cc ? cc_level : pixel_in;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pixel_out <= 10'h000;
    end else begin
      pixel_out <= next_pixel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cc_active <= 1'b0;
    end else begin
      cc_active <= on_cc;
    end
  end
endmodule : closed_caption_inserter

// ==== tb/cc_checker.sv ====
// Port assertions for the caption inserter
`timescale 1ns/10ps
`include "cc_regs.svh"
module cc_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire cc_pkg::timing_t timing,
  input wire logic [9:0] pixel_in,
  input wire logic [9:0] pixel_out,
  input wire logic cc_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire logic odd_hit = timing.odd_field && timing.line == `CC_ODD_LINE;
  wire logic even_hit = !timing.odd_field && timing.line == `CC_EVEN_LINE;
  wire logic hi_lvl = pixel_out == `CC_LEVEL_HIGH;
  odd_rise_a: assert property (timing.line_start && odd_hit |=> cc_active)
    else $error("odd caption line not started");
  even_rise_a: assert property (timing.line_start && even_hit |=> cc_active)
    else $error("even caption line not started");
  plain_drop_a: assert property (timing.line_start && !odd_hit && !even_hit |=> !cc_active)
    else $error("caption on a plain line");
  line_hold_a: assert property (cc_active && !timing.line_start |=> cc_active)
    else $error("caption line cut short");
  pass_thru_a: assert property (!cc_active && !$past(srst)
    |-> pixel_out == $past(pixel_in)) else $error("pixel not passed");
  wait_blank_a: assert property ($rose(cc_active) |-> (pixel_out == `CC_LEVEL_BLANK) [*8])
    else $error("caption line not blank at start");
  level_set_a: assert property (cc_active |-> hi_lvl || pixel_out == `CC_LEVEL_BLANK)
    else $error("pixel input leaks into caption");
  reset_out_a: assert property ($fell(srst) |-> !cc_active && pixel_out == 10'h000)
    else $error("outputs not cleared by reset");
endmodule : cc_checker

// ==== tb/cc_receiver.sv ====
// Receiver model that slices the caption waveform
`timescale 1ns/10ps
`include "cc_regs.svh"
module cc_receiver #(
  parameter int BIT_CLKS = 19,
  parameter int START_CLKS = 100
) (
  input wire logic clk_sys,
  input wire logic cc_active,
  input wire logic [9:0] pixel_out,
  output logic [25:0] seen,
  output logic done
);
  int c;
  int k;
  // Early slice in run-in catches the high half; others at mid bit
  initial begin
    seen = '0;
    done = 1'b0;
    forever begin
      @(posedge cc_active);
      done = 1'b0;
      for (c = 0; c < START_CLKS + 26 * BIT_CLKS; c++) begin
        @(posedge clk_sys);
        k = (c - START_CLKS) / BIT_CLKS;
        if (c >= START_CLKS && (c - START_CLKS) % BIT_CLKS == (k < 7 ? 4 : 9)) begin
          seen[k] = (pixel_out === `CC_LEVEL_HIGH);
        end
      end
      done = 1'b1;
    end
  end
endmodule : cc_receiver

// ==== tb/tb_top.sv ====
// Self-checking bench for the caption inserter
`timescale 1ns/10ps
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  cc_pkg::reg_wr_t wr = '0;
  cc_pkg::timing_t timing = '0;
  logic [9:0] pixel_in = 10'h123;
  logic [9:0] pixel_out;
  logic cc_active;
  logic [25:0] seen;
  logic done;
  int err_count = 0;
  int num_checks = 0;
  always #50 clk_sys = ~clk_sys;
  closed_caption_inserter u_closed_caption_inserter (.clk_sys(clk_sys), .srst(srst), .wr(wr),
    .timing(timing), .pixel_in(pixel_in), .pixel_out(pixel_out), .cc_active(cc_active));
  cc_receiver u_cc_receiver (.clk_sys(clk_sys), .cc_active(cc_active), .pixel_out(pixel_out),
    .seen(seen), .done(done));
  task automatic step();
    @(posedge clk_sys);
    #5;
  endtask : step
  function automatic logic [25:0] frame(input logic [7:0] lo, input logic [7:0] hi);
    return {~^hi[6:0], hi[6:0], ~^lo[6:0], lo[6:0], 3'b100, 7'h7F};
  endfunction : frame
  task automatic put2(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    wr = '{addr: a, data: lo, we: 1'b1};
    step();
    wr = '{addr: a + 8'h01, data: hi, we: 1'b1};
    step();
    // Idle edge so a following write never re-raises we in the same step
    wr = '0;
    step();
  endtask : put2
  task automatic cap(input logic o, input logic [9:0] l, input logic [25:0] exp);
    timing = '{line: l, odd_field: o, line_start: 1'b1};
    step();
    timing.line_start = 1'b0;
    `CHECK(cc_active, 1'b1)
    for (int i = 0; i < 1000 && done !== 1'b1; i++) step();
    if (done !== 1'b1) begin
      err_count++;
      complete_run();
    end
    `CHECK(seen, exp)
    timing = '{line: 10'h016, odd_field: o, line_start: 1'b1};
    step();
    timing.line_start = 1'b0;
    `CHECK(cc_active, 1'b0)
    `CHECK(pixel_out, pixel_in)
    pixel_in = 10'h2A5;
    step();
    `CHECK(cc_active, 1'b0)
    `CHECK(pixel_out, 10'h2A5)
  endtask : cap
  task automatic t_odd();
    put2(8'h13, 8'hC1, 8'h2A);
    put2(8'h15, 8'hFF, 8'hFF);
    cap(1'b1, 10'h015, frame(8'hC1, 8'h2A));
    $display("odd test done");
  endtask : t_odd
  task automatic t_even();
    put2(8'h11, 8'h00, 8'h7F);
    cap(1'b0, 10'h11C, frame(8'h00, 8'h7F));
    $display("even test done");
  endtask : t_even
  task automatic t_null();
    put2(8'h13, 8'h00, 8'h00);
    cap(1'b1, 10'h015, frame(8'h00, 8'h00));
    $display("null test done");
  endtask : t_null
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge clk_sys);
    #5 srst = 1'b0;
    t_odd();
    t_even();
    t_null();
    complete_run();
  end
endmodule : tb_top
bind closed_caption_inserter cc_checker u_cc_checker (.clk_sys(clk_sys), .srst(srst),
  .timing(timing), .pixel_in(pixel_in), .pixel_out(pixel_out), .cc_active(cc_active));
